/* src/sbp_pkg.sv */
// shared constants, register map and types of the serial byte packer
package sbp_pkg;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int unsigned CLK_PERIOD_NS = 4;
	localparam int unsigned TICK_PERIOD_NS = 1_000_000;
	localparam int unsigned TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;

	// ----------------------------------------
	// sizes
	// ----------------------------------------
	localparam int unsigned BUF_BYTES = 1024;
	localparam int unsigned FIFO_DEPTH = 16;

	// ----------------------------------------
	// register map (byte addresses)
	// ----------------------------------------
	localparam logic [11:0] ADDR_LEN = 12'h000;
	localparam logic [11:0] ADDR_MARK = 12'h004;
	localparam logic [11:0] ADDR_IDLE = 12'h008;
	localparam logic [11:0] ADDR_STAT = 12'h00C;
	localparam logic [11:0] ADDR_FRAMES = 12'h010;

	// mark register fields
	localparam int unsigned MARK_D1_LSB = 0;
	localparam int unsigned MARK_D2_LSB = 8;
	localparam int unsigned MARK_TWO_BIT = 16;
	localparam int unsigned MARK_POST_LSB = 17;

	// reset values
	localparam logic [10:0] LEN_RST = 11'h000;
	localparam logic [18:0] MARK_RST = 19'h1_0000;
	localparam logic [15:0] IDLE_RST = 16'h0000;

	// bus answers
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef enum logic [1:0] {
		POST_NONE = 2'b00,
		POST_ONE = 2'b01,
		POST_TWO = 2'b10
	} sbp_post_t;

	typedef enum logic [1:0] {
		ST_HUNT = 2'b00,
		ST_GOT1 = 2'b01,
		ST_TAIL = 2'b11
	} sbp_state_t;

	typedef struct packed {
		logic last;
		logic [7:0] data;
	} sbp_item_t;

endpackage

/* src/sbp_top.sv */
// serial byte packer: frame builder, output fifo and register slave
//
// Added by the designer: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps

// ----------------------------------------
// output fifo
// ----------------------------------------
module sbp_fifo #(
	parameter int unsigned WIDTH = 9,
	parameter int unsigned DEPTH = 16
) (
	input  wire logic             aclk,     // clock
	input  wire logic             aresetn,  // sync reset, low
	input  wire logic [WIDTH-1:0] in_data,  // write word
	input  wire logic             in_valid, // write request
	output logic                  in_ready, // room left
	output logic      [WIDTH-1:0] out_data, // head word
	output logic                  out_valid,// head present
	input  wire logic             out_ready // head taken
);
	localparam int unsigned AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wr_ptr;
	logic [AW:0]      rd_ptr;
	logic             do_wr;
	logic             do_rd;

	// extra pointer bit tells full from empty
	assign in_ready = (wr_ptr[AW] == rd_ptr[AW]) || (wr_ptr[AW-1:0] != rd_ptr[AW-1:0]);
	assign out_valid = (wr_ptr != rd_ptr);
	assign out_data = mem[rd_ptr[AW-1:0]];
	assign do_wr = in_valid && in_ready;
	assign do_rd = out_valid && out_ready;

	// storage
	always_ff @(posedge aclk) begin
		if (do_wr) begin
			mem[wr_ptr[AW-1:0]] <= in_data;
		end
	end

	// pointers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			if (do_wr) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (do_rd) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
		end
	end
endmodule

// Functional notes
// - zero length limit means no length flush
// - flush when byte count reaches length limit
// - no marker set: every byte sent alone
// - marker set: hold bytes until marker seen
// - 8-bit markers, zero second means single
// - full 1K buffer forces a flush
// - one-byte match: either marker flushes
// - two-byte match: first then second marker
// - match mode resets to two bytes
// - tail bytes need first marker, full sequence
// - flush at marker or one/two bytes later
// - tail handling resets to none
// - zero idle timeout disables idle flush
// - idle gap of timeout ms flushes buffer
module sbp_top import sbp_pkg::*; #(
	parameter int unsigned TICK_CNT = TICK_CYCLES
) (
	input  wire logic        aclk,          // 250 MHz clock
	input  wire logic        aresetn,       // sync reset, low
	input  wire logic [11:0] s_axi_awaddr,  // write address
	input  wire logic        s_axi_awvalid, // write address valid
	output logic             s_axi_awready, // write address ready
	input  wire logic [31:0] s_axi_wdata,   // write data
	input  wire logic [3:0]  s_axi_wstrb,   // byte enables
	input  wire logic        s_axi_wvalid,  // write data valid
	output logic             s_axi_wready,  // write data ready
	output logic [1:0]       s_axi_bresp,   // write answer
	output logic             s_axi_bvalid,  // write answer valid
	input  wire logic        s_axi_bready,  // write answer ready
	input  wire logic [11:0] s_axi_araddr,  // read address
	input  wire logic        s_axi_arvalid, // read address valid
	output logic             s_axi_arready, // read address ready
	output logic [31:0]      s_axi_rdata,   // read data
	output logic [1:0]       s_axi_rresp,   // read answer
	output logic             s_axi_rvalid,  // read answer valid
	input  wire logic        s_axi_rready,  // read answer ready
	input  wire logic [7:0]  ser_tdata,     // serial byte in
	input  wire logic        ser_tvalid,    // serial byte valid
	output logic             ser_tready,    // serial byte taken
	output logic [7:0]       net_tdata,     // frame byte out
	output logic             net_tlast,     // last byte of frame
	output logic             net_tvalid,    // frame byte valid
	input  wire logic        net_tready     // network takes byte
);
	// ----------------------------------------
	// declarations
	// ----------------------------------------
	logic [10:0] reg_len;
	logic [18:0] reg_mark;
	logic [15:0] reg_idle;
	logic [31:0] frames;
	logic [11:0] aw_addr;
	logic        aw_held;
	logic [31:0] w_data;
	logic [3:0]  w_strb;
	logic        w_held;
	sbp_state_t  state;
	sbp_state_t  next_state;
	logic [1:0]  extra;
	logic [1:0]  next_extra;
	logic [10:0] cnt;
	logic [10:0] cnt_inc;
	logic        held_v;
	logic        held_l;
	logic [7:0]  held_d;
	logic [31:0] div_cnt;
	logic        ms_tick;
	logic [15:0] idle_ms;
	logic        idle_hit;
	logic [7:0]  d1;
	logic [7:0]  d2;
	logic        d1_on;
	logic        d2_on;
	logic        marker_on;
	logic        two_mode;
	sbp_post_t   post;
	logic        hit1;
	logic        hit2;
	logic        mk_event;
	logic        mk_end;
	logic        len_hit;
	logic        full_hit;
	logic        end_byte;
	logic        in_fire;
	logic        push_v;
	logic        push_fire;
	logic        flush_idle;
	logic        fifo_ready;
	sbp_item_t   push_item;
	sbp_item_t   pop_item;
	logic        wr_go;
	logic        wr_len;
	logic        wr_mark;
	logic        wr_idle;
	logic        wr_ro;
	logic [31:0] rd_word;
	logic        rd_ok;
	logic [31:0] stat_word;

	// apply byte enables to a stored word
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
	                                      input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[8*i +: 8] = nw[8*i +: 8];
			end
		end
		return res;
	endfunction

	// ----------------------------------------
	// register bus slave
	// ----------------------------------------
	// address and data may arrive in either order; each is parked until both are in
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready = !w_held && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	assign wr_go = aw_held && w_held && !s_axi_bvalid;

	// write decode
	assign wr_len = (aw_addr == ADDR_LEN);
	assign wr_mark = (aw_addr == ADDR_MARK);
	assign wr_idle = (aw_addr == ADDR_IDLE);
	assign wr_ro = (aw_addr == ADDR_STAT) || (aw_addr == ADDR_FRAMES);

	// read decode, unmapped reads give zero and an error answer
	assign stat_word = {11'h000, held_v, extra, state, 5'h00, cnt};
	assign rd_ok = (s_axi_araddr == ADDR_LEN) || (s_axi_araddr == ADDR_MARK) || (s_axi_araddr == ADDR_IDLE)
	               || (s_axi_araddr == ADDR_STAT) || (s_axi_araddr == ADDR_FRAMES);
	always_comb begin
		if (s_axi_araddr == ADDR_LEN) begin
			rd_word = {21'h00_0000, reg_len};
		end else if (s_axi_araddr == ADDR_MARK) begin
			rd_word = {13'h0000, reg_mark};
		end else if (s_axi_araddr == ADDR_IDLE) begin
			rd_word = {16'h0000, reg_idle};
		end else if (s_axi_araddr == ADDR_STAT) begin
			rd_word = stat_word;
		end else if (s_axi_araddr == ADDR_FRAMES) begin
			rd_word = frames;
		end else begin
			rd_word = 32'h0000_0000;
		end
	end

	// parked write channels
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 12'h000;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end else if (wr_go) begin
				aw_held <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end else if (wr_go) begin
				w_held <= 1'b0;
			end
		end
	end

	// write answer
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= (wr_len || wr_mark || wr_idle || wr_ro) ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// read answer
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_word;
			s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// configuration registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			reg_len <= LEN_RST;
			reg_mark <= MARK_RST;
			reg_idle <= IDLE_RST;
		end else if (wr_go) begin
			if (wr_len) begin
				reg_len <= 11'(merge({21'h00_0000, reg_len}, w_data, w_strb));
			end
			if (wr_mark) begin
				reg_mark <= 19'(merge({13'h0000, reg_mark}, w_data, w_strb));
			end
			if (wr_idle) begin
				reg_idle <= 16'(merge({16'h0000, reg_idle}, w_data, w_strb));
			end
		end
	end

	// ----------------------------------------
	// configuration fields
	// ----------------------------------------
	assign d1 = reg_mark[MARK_D1_LSB +: 8];
	assign d2 = reg_mark[MARK_D2_LSB +: 8];
	assign post = sbp_post_t'(reg_mark[MARK_POST_LSB +: 2]);
	assign d1_on = (d1 != 8'h00);
	assign d2_on = (d2 != 8'h00);
	assign marker_on = d1_on || d2_on;
	// sequence matching only when both markers exist
	assign two_mode = reg_mark[MARK_TWO_BIT] && d1_on && d2_on;

	// ----------------------------------------
	// millisecond tick and idle timer
	// ----------------------------------------
	// divider restarts with each byte so the gap is measured from that byte
	assign ms_tick = (div_cnt == 32'(TICK_CNT - 1));
	always_ff @(posedge aclk) begin
		if (!aresetn || in_fire || ms_tick) begin
			div_cnt <= 32'h0000_0000;
		end else begin
			div_cnt <= div_cnt + 32'h0000_0001;
		end
	end

	// counts whole ms since the last byte, saturating so a timeout set while bytes wait still fires
	always_ff @(posedge aclk) begin
		if (!aresetn || in_fire || push_fire) begin
			idle_ms <= 16'h0000;
		end else if (ms_tick && !idle_hit && idle_ms != 16'hFFFF) begin
			idle_ms <= idle_ms + 16'h0001;
		end
	end
	assign idle_hit = (reg_idle != 16'h0000) && (idle_ms >= reg_idle)
	                  && held_v && !held_l;

	// ----------------------------------------
	// frame decision for each arriving byte
	// ----------------------------------------
	assign in_fire = ser_tvalid && ser_tready;
	assign cnt_inc = cnt + 11'h001;
	assign hit1 = d1_on && (ser_tdata == d1);
	assign hit2 = d2_on && (ser_tdata == d2);
	assign len_hit = (reg_len != 11'h000) && (cnt_inc == reg_len);
	assign full_hit = (cnt_inc == 11'(BUF_BYTES));

	// marker matcher, tail bytes skip matching
	always_comb begin
		next_state = state;
		next_extra = extra;
		mk_event = 1'b0;
		mk_end = 1'b0;
		case (state)
			ST_HUNT: begin
				if (two_mode) begin
					if (hit1) begin
						next_state = ST_GOT1;
					end
				end else begin
					mk_event = hit1 || hit2;
				end
			end
			ST_GOT1: begin
				if (hit2) begin
					mk_event = 1'b1;
				end else if (!hit1) begin
					next_state = ST_HUNT;
				end
			end
			ST_TAIL: begin
				next_extra = extra - 2'b01;
				mk_end = (extra == 2'b01);
			end
			default: begin
				next_state = ST_HUNT;
			end
		endcase
		if (mk_event) begin
			// tail handling needs the first marker enabled
			if (d1_on && post != POST_NONE) begin
				next_state = ST_TAIL;
				next_extra = (post == POST_ONE) ? 2'b01 : 2'b10;
			end else begin
				mk_end = 1'b1;
			end
		end
	end

	// no marker at all: each byte is its own frame
	assign end_byte = !marker_on || mk_end || len_hit || full_hit;

	// ----------------------------------------
	// one-byte staging ahead of the fifo
	// ----------------------------------------
	// the newest byte waits here so an idle flush can still tag it last
	assign ser_tready = !held_v || fifo_ready;
	assign push_v = held_v && (held_l || ser_tvalid || idle_hit);
	assign push_fire = push_v && fifo_ready;
	assign flush_idle = push_fire && idle_hit && !in_fire;
	assign push_item.data = held_d;
	assign push_item.last = held_l || (idle_hit && !in_fire);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			held_v <= 1'b0;
			held_l <= 1'b0;
			held_d <= 8'h00;
		end else if (in_fire) begin
			held_v <= 1'b1;
			held_l <= end_byte;
			held_d <= ser_tdata;
		end else if (push_fire) begin
			held_v <= 1'b0;
		end
	end

	// count and matcher state, cleared on every flush
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt <= 11'h000;
			state <= ST_HUNT;
			extra <= 2'b00;
		end else if (in_fire) begin
			if (end_byte) begin
				cnt <= 11'h000;
				state <= ST_HUNT;
				extra <= 2'b00;
			end else begin
				cnt <= cnt_inc;
				state <= marker_on ? next_state : ST_HUNT;
				extra <= next_extra;
			end
		end else if (flush_idle) begin
			cnt <= 11'h000;
			state <= ST_HUNT;
			extra <= 2'b00;
		end
	end

	// frames handed to the network path
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			frames <= 32'h0000_0000;
		end else if (push_fire && push_item.last) begin
			frames <= frames + 32'h0000_0001;
		end
	end

	// ----------------------------------------
	// output fifo toward the network
	// ----------------------------------------
	sbp_fifo #(
		.WIDTH ($bits(sbp_item_t)),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.in_data   (push_item),
		.in_valid  (push_v),
		.in_ready  (fifo_ready),
		.out_data  (pop_item),
		.out_valid (net_tvalid),
		.out_ready (net_tready)
	);
	assign net_tdata = pop_item.data;
	assign net_tlast = pop_item.last;
endmodule

/* bench/sbp_props.sv */
// concurrent checks on the ports of the serial byte packer
`timescale 1ns/1ps
module sbp_props import sbp_pkg::*; (
	input wire logic        aclk,          // clock
	input wire logic        aresetn,       // sync reset, low
	input wire logic [11:0] s_axi_awaddr,  // aw addr
	input wire logic        s_axi_awvalid, // aw valid
	input wire logic        s_axi_awready, // aw ready
	input wire logic [31:0] s_axi_wdata,   // w data
	input wire logic        s_axi_wvalid,  // w valid
	input wire logic        s_axi_wready,  // w ready
	input wire logic        s_axi_bvalid,  // b valid
	input wire logic        s_axi_bready,  // b ready
	input wire logic        s_axi_arvalid, // ar valid
	input wire logic        s_axi_arready, // ar ready
	input wire logic [31:0] s_axi_rdata,   // r data
	input wire logic        s_axi_rvalid,  // r valid
	input wire logic        s_axi_rready,  // r ready
	input wire logic [7:0]  net_tdata,     // net byte
	input wire logic        net_tlast,     // frame end
	input wire logic        net_tvalid,    // net valid
	input wire logic        net_tready     // net ready
);
	logic [10:0] len_sh;
	logic [15:0] mk_sh;
	logic [10:0] fcnt;
	wire         wr_hs = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;

	// shadow of limit and markers; only same-cycle writes are seen, the bench issues no other kind
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			len_sh <= LEN_RST;
			mk_sh <= 16'h0000;
			fcnt <= 11'h000;
		end else begin
			if (wr_hs && s_axi_awaddr == ADDR_LEN)
				len_sh <= s_axi_wdata[10:0];
			if (wr_hs && s_axi_awaddr == ADDR_MARK)
				mk_sh <= s_axi_wdata[15:0];
			if (net_tvalid && net_tready)
				fcnt <= net_tlast ? 11'h000 : fcnt + 11'h001;
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_reset_quiet: assert property ($rose(aresetn) |-> !net_tvalid && !s_axi_bvalid && !s_axi_rvalid)
		else $error("outputs busy after reset");
	a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	a_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer dropped");
	a_wr_answer: assert property (wr_hs |-> ##2 s_axi_bvalid)
		else $error("write answer late");
	a_wr_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write answer dropped");
	a_net_hold: assert property (net_tvalid && !net_tready |=> net_tvalid && $stable({net_tdata, net_tlast}))
		else $error("net byte changed while stalled");
	a_single_byte: assert property (net_tvalid && mk_sh == 16'h0000 |-> net_tlast)
		else $error("byte not sent alone");
	a_len_limit: assert property (net_tvalid && len_sh != 11'h000 && len_sh <= 11'd1024 &&
		fcnt == len_sh - 11'd1 |-> net_tlast)
		else $error("frame longer than limit");
	a_full_flush: assert property (net_tvalid && fcnt == 11'd1023 |-> net_tlast)
		else $error("frame longer than buffer");
endmodule

bind sbp_top sbp_props chk_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
	.s_axi_rvalid, .s_axi_rready, .net_tdata, .net_tlast, .net_tvalid, .net_tready);

/* bench/sbp_host_model.sv */
// host system model that offers serial bytes to the packer
`timescale 1ns/1ps
module sbp_host_model (
	input  wire logic aclk,       // clock
	input  wire logic aresetn,    // sync reset, low
	input  wire logic gap,        // hold off next byte
	input  wire logic ser_tready, // byte taken
	output logic [7:0] ser_tdata, // byte out
	output logic      ser_tvalid  // byte offered
);
	logic [7:0] q[$];

	// each byte held until taken; idle data toggles so a stale byte never looks valid
	always @(posedge aclk) begin
		if (!aresetn) begin
			ser_tvalid <= 1'b0;
			ser_tdata <= 8'h00;
		end else if (!ser_tvalid || ser_tready) begin
			if (q.size() > 0 && !gap) begin
				ser_tdata <= q.pop_front();
				ser_tvalid <= 1'b1;
			end else begin
				ser_tvalid <= 1'b0;
				ser_tdata <= ~ser_tdata;
			end
		end
	end
endmodule

/* bench/sbp_top_tb.sv */
// self-checking bench for the serial byte packer
`timescale 1ns/1ps
module sbp_top_tb import sbp_pkg::*; ;
	localparam int unsigned TK = 10;
	logic aclk = 0, aresetn = 0, gap = 0, hold = 0, stall = 1, saw_full = 0;
	logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic net_tready = 0;
	wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire logic [1:0] s_axi_bresp, s_axi_rresp;
	wire logic [31:0] s_axi_rdata;
	wire logic [7:0] ser_tdata, net_tdata;
	wire logic ser_tvalid, ser_tready, net_tlast, net_tvalid;
	logic [7:0] m1 = 0, m2 = 0;
	logic two = 1;
	logic [1:0] post = 0;
	logic [10:0] len = 0;
	logic [15:0] idle = 0;
	logic [8:0] got[$], exp_q[$];
	int seed = 57, error_cnt = 0, n_compared = 0, cnt = 0, st = 0, tl = 0, since = 0, n_fr = 0;

	sbp_top #(.TICK_CNT(TK)) dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .ser_tdata, .ser_tvalid, .ser_tready, .net_tdata, .net_tlast, .net_tvalid, .net_tready);
	sbp_host_model host (.aclk, .aresetn, .gap, .ser_tready, .ser_tdata, .ser_tvalid);

	always #2 aclk = ~aclk;

	// network sink stalls a quarter of the time; short gaps keep idle flush out of mid-burst
	always @(posedge aclk) begin
		net_tready <= !hold && (!stall || $random(seed) % 4 != 0);
		gap <= stall && ($random(seed) % 4 == 0);
		since <= (ser_tvalid && ser_tready) ? 0 : since + 1;
		if (aresetn && !ser_tready)
			saw_full <= 1;
		if (aresetn && net_tvalid && net_tready)
			got.push_back({net_tlast, net_tdata});
	end

	task chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
		n_compared++;
		if (seen !== ex) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", nm, ex, seen);
		end
	endtask

	task conclude;
		$display("compared %0d, mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// answer ready is raised only once the answer shows, so stalled answers get exercised
	task wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
		logic ha, hw, v, p;
		logic [1:0] r;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		forever begin
			@(negedge aclk);
			ha = s_axi_awvalid && s_axi_awready;
			hw = s_axi_wvalid && s_axi_wready;
			v = s_axi_bvalid && s_axi_bready;
			p = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge aclk);
			if (ha)
				s_axi_awvalid <= 0;
			if (hw)
				s_axi_wvalid <= 0;
			if (v)
				break;
			if (p)
				s_axi_bready <= 1;
		end
		s_axi_bready <= 0;
		chk("bresp", r, er);
	endtask

	task rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
		logic h, v, p;
		logic [31:0] d;
		logic [1:0] r;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		forever begin
			@(negedge aclk);
			h = s_axi_arvalid && s_axi_arready;
			v = s_axi_rvalid && s_axi_rready;
			p = s_axi_rvalid;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge aclk);
			if (h)
				s_axi_arvalid <= 0;
			if (v)
				break;
			if (p)
				s_axi_rready <= 1;
		end
		s_axi_rready <= 0;
		chk("rdata", d, ed);
		chk("rresp", r, er);
	endtask

	// reference framer: returns whether a byte closes its frame
	function automatic logic is_end(input logic [7:0] b);
		logic ev, e;
		ev = 0;
		e = 0;
		cnt++;
		if (st == 2) begin
			tl--;
			e = (tl == 0);
		end else begin
			if (two && m1 != 0 && m2 != 0) begin
				ev = (st == 1 && b == m2);
				st = (b == m1) ? 1 : 0;
			end else
				ev = (m1 != 0 && b == m1) || (m2 != 0 && b == m2);
			if (ev && post != 0 && m1 != 0) begin
				st = 2;
				tl = (post == 3) ? 2 : post;
			end else
				e = ev;
		end
		e = e || (m1 == 0 && m2 == 0) || (len != 0 && len <= 1024 && cnt == len) || cnt == 1024;
		if (e) begin
			cnt = 0;
			st = 0;
		end
		return e;
	endfunction

	task cfg(input logic [7:0] a, b, input logic t, input logic [1:0] p, input logic [10:0] l, input logic [15:0] i);
		m1 = a;
		m2 = b;
		two = t;
		post = p;
		len = l;
		idle = i;
		wr(ADDR_LEN, {21'h0, l}, RESP_OKAY);
		wr(ADDR_MARK, {13'h0, p, t, b, a}, RESP_OKAY);
		wr(ADDR_IDLE, {16'h0, i}, RESP_OKAY);
		rd(ADDR_MARK, {13'h0, p, t, b, a}, RESP_OKAY);
	endtask

	task feed(input int n, input logic [7:0] mask);
		logic [7:0] b;
		for (int i = 0; i < n; i++) begin
			b = 8'($random(seed)) & mask;
			host.q.push_back(b);
			exp_q.push_back({is_end(b), b});
		end
		if (cnt != 0 && idle != 0)
			exp_q[$][8] = 1'b1;
	endtask

	task cmpq;
		int k;
		for (k = 0; k < 6000 && got.size() < exp_q.size(); k++)
			@(posedge aclk);
		repeat (8) @(posedge aclk);
		chk("byte_count", got.size(), exp_q.size());
		for (k = 0; k < exp_q.size() && k < got.size(); k++)
			chk("net_byte", got[k], exp_q[k]);
		foreach (exp_q[j])
			n_fr += exp_q[j][8];
		got = {};
		exp_q = {};
		cnt = 0;
		st = 0;
	endtask

	task go(input logic [7:0] a, b, input logic t, input logic [1:0] p, input logic [10:0] l, input int n,
		input logic [7:0] mask);
		cfg(a, b, t, p, l, 16'h0003);
		feed(n, mask);
		cmpq;
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		int k;
		repeat (20) @(posedge aclk);
		aresetn <= 1;
		rd(ADDR_LEN, 32'h0, RESP_OKAY);
		rd(ADDR_MARK, 32'h0001_0000, RESP_OKAY);
		rd(ADDR_IDLE, 32'h0, RESP_OKAY);
		rd(12'h020, 32'h0, RESP_SLVERR);
		wr(12'h020, 32'hFFFF_FFFF, RESP_SLVERR);
		hold <= 1;
		feed(40, 8'hFF);
		repeat (40) @(posedge aclk);
		hold <= 0;
		chk("fifo_full", saw_full, 1);
		cmpq;
		go(8'h03, 8'h05, 1, 0, 0, 60, 8'h07);
		go(8'h03, 8'h05, 0, 0, 0, 60, 8'h07);
		go(8'h03, 8'h00, 1, 0, 0, 60, 8'h07);
		go(8'h03, 8'h05, 1, 1, 0, 60, 8'h07);
		go(8'h03, 8'h00, 0, 2, 0, 60, 8'h07);
		go(8'h00, 8'h05, 0, 1, 0, 60, 8'h07);
		go(8'h03, 8'h05, 1, 3, 5, 60, 8'h07);
		go(8'hAA, 8'h00, 0, 0, 7, 50, 8'hFF);
		go(8'hAA, 8'h00, 0, 0, 1, 10, 8'hFF);
		go(8'h80, 8'h00, 0, 0, 0, 1030, 8'h7F);
		cfg(8'h80, 8'h00, 0, 0, 0, 16'h0000);
		feed(10, 8'h7F);
		repeat (200) @(posedge aclk);
		chk("held_bytes", got.size(), 9);
		wr(ADDR_IDLE, 32'h3, RESP_OKAY);
		exp_q[$][8] = 1'b1;
		cmpq;
		stall <= 0;
		cfg(8'h03, 8'h05, 1, 0, 0, 16'h0003);
		host.q.push_back(8'h41);
		exp_q.push_back(9'h041);
		repeat (25) @(posedge aclk);
		host.q.push_back(8'h42);
		exp_q.push_back(9'h142);
		for (k = 0; k < 100 && !(net_tvalid && net_tlast); k++)
			@(negedge aclk);
		chk("idle_gap", since >= 28 && since <= 36, 1);
		cmpq;
		rd(ADDR_FRAMES, n_fr, RESP_OKAY);
		conclude;
	end

	// watchdog well beyond the expected run length
	initial begin
		repeat (40000) @(posedge aclk);
		error_cnt++;
		conclude;
	end
endmodule
